// >>> ipsec_sa_lookup_antireplay.sv
// Association lookup, replay window and policy match for an ESP engine.
// Assumes host and datapath inputs are synchronous to clk; one clock.
//
// Function
// - Keep a 5-bit flag word per receive association, read via matched index.
// - Matched association with active flag clear counts as miss and drops.
// - Extended-sequence flag selects 64-bit numbers; upper word inferred from window top.
// - Replay enabled: drop and flag duplicates or numbers below the window.
// - Window top and bitmap update for committed packets that pass the window check, regardless of replay enable.
// - Packets already dropped never update window state nor get replay flagged.
// - Data memory: four words per entry, address 1:0 word, 9:2 index.
// - Word codes: 00 top high, 01 top low, 10 salt, 11 bitmap.
// - A 64-bit window top holds highest accepted extended sequence number.
// - Infer untransmitted upper sequence word from window top; use in replay check.
// - Nonce is the 32-bit salt joined with the packet vector.
// - Bitmap covers 32 numbers ending at window top; one means seen.
// - Key memory: eight words per entry, address 2:0 word, 10:3 index.
// - Key word 0 holds the most significant key bits.
// - Policy word codes: dst, dst mask, src, src mask, active, index.
// - Policy compares source and destination; mask ones always match.
// - Policy entry with active clear never matches.
// - Policy hit reads transmit association memory at stored index.
// - Flag bits 1:0 give key length: 00 is 128, 10 is 256.
// - No receive index entry matching the SPI raises miss and drops.
// - All tables reachable by the host over a 32-bit data bus.
`timescale 1ns/1ps

module ipsec_sa_lookup_antireplay import sa_lookup_pkg::*; (
	// Clock and reset
	input  wire logic                              clk,
	input  wire logic                              reset_n,
	// Host table access
	input  wire logic                              host_sel,
	input  wire logic                              host_write,
	input  wire logic [sa_lookup_pkg::ADDR_W-1:0]  host_addr,
	input  wire logic [sa_lookup_pkg::DATA_W-1:0]  host_wdata,
	output logic      [sa_lookup_pkg::DATA_W-1:0]  host_rdata,
	output logic                                   host_rvalid,
	// Receive lookup request
	input  wire logic                              rx_lookup_req,
	input  wire logic [31:0]                       rx_spi,
	input  wire logic [31:0]                       rx_seq_low,
	input  wire logic [sa_lookup_pkg::IV_W-1:0]    rx_iv,
	// Receive lookup answer
	output logic                                   rx_lookup_done,
	output logic                                   rx_miss,
	output logic                                   rx_replay,
	output logic                                   rx_drop,
	output logic      [sa_lookup_pkg::IDX_W-1:0]   rx_index,
	output logic      [1:0]                        rx_key_len,
	output logic      [sa_lookup_pkg::KEY_W-1:0]   rx_key,
	output logic      [sa_lookup_pkg::NONCE_W-1:0] rx_nonce,
	output logic      [31:0]                       rx_seq_high,
	output logic                                   rx_busy,
	// Receive commit after integrity check
	input  wire logic                              rx_commit_req,
	input  wire logic                              rx_commit_drop,
	output logic                                   rx_commit_done,
	// Transmit policy lookup
	input  wire logic                              tx_lookup_req,
	input  wire logic [31:0]                       tx_src,
	input  wire logic [31:0]                       tx_dst,
	output logic                                   tx_lookup_done,
	output logic                                   tx_hit,
	output logic      [sa_lookup_pkg::IDX_W-1:0]   tx_index,
	output logic                                   tx_busy,
	// Transmit association memory read
	output logic                                   tx_sa_read_en,
	output logic      [sa_lookup_pkg::IDX_W-1:0]   tx_sa_read_index
);
	import sa_lookup_pkg::*;

	// ---------------------------------------------------------------
	// Reset release
	// ---------------------------------------------------------------
	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ---------------------------------------------------------------
	// Tables
	// ---------------------------------------------------------------
	logic [31:0]        spi_cam_mem [0:ENTRIES-1];
	logic [FLAGS_W-1:0] flags_mem   [0:ENTRIES-1];
	logic [31:0]        top_hi_mem  [0:ENTRIES-1];
	logic [31:0]        top_lo_mem  [0:ENTRIES-1];
	logic [31:0]        salt_mem    [0:ENTRIES-1];
	logic [31:0]        bitmap_mem  [0:ENTRIES-1];
	logic [31:0]        key_mem     [0:ENTRIES*KEY_WORDS-1];
	logic [31:0]        pol_dst     [0:ENTRIES-1];
	logic [31:0]        pol_dmask   [0:ENTRIES-1];
	logic [31:0]        pol_src     [0:ENTRIES-1];
	logic [31:0]        pol_smask   [0:ENTRIES-1];
	logic               pol_active  [0:ENTRIES-1];
	logic [IDX_W-1:0]   pol_index   [0:ENTRIES-1];

	// ---------------------------------------------------------------
	// Host address decode
	// ---------------------------------------------------------------
	logic             hit_spi;
	logic             hit_flags;
	logic             hit_data;
	logic             hit_key;
	logic             hit_pol;
	logic [IDX_W-1:0] idx_spi;
	logic [IDX_W-1:0] idx_data;
	logic [IDX_W-1:0] idx_key;
	logic [1:0]       word_data;
	logic [2:0]       word_pol;
	logic             host_wr;

	assign hit_spi   = host_addr[13:8] == SPI_CAM_REGION;
	assign hit_flags = host_addr[13:8] == FLAGS_REGION;
	assign hit_data  = host_addr[13:10] == DATA_REGION;
	assign hit_key   = host_addr[13:11] == KEY_REGION;
	assign hit_pol   = host_addr[13:11] == POLICY_REGION;
	assign idx_spi   = host_addr[7:0];
	assign idx_data  = host_addr[9:2];
	assign word_data = host_addr[1:0];
	assign idx_key   = host_addr[10:3];
	assign word_pol  = host_addr[2:0];
	assign host_wr   = host_sel && host_write;

	// ---------------------------------------------------------------
	// Receive state and window arithmetic
	// ---------------------------------------------------------------
	rx_state_t        rx_state_r;
	logic [IDX_W-1:0] rx_scan_r;
	logic [IDX_W-1:0] rx_idx_r;
	logic             rx_miss_r;
	logic [31:0]      spi_r;
	logic [31:0]      seq_low_r;
	logic [IV_W-1:0]  iv_r;

	logic [IDX_W-1:0] sel_idx;
	logic [FLAGS_W-1:0] sel_flags;
	logic             esn;
	logic [31:0]      top_hi;
	logic [31:0]      top_lo;
	logic [31:0]      lo_floor;
	logic [31:0]      seq_hi;
	logic [63:0]      top64;
	logic [63:0]      seq64;
	logic [63:0]      behind;
	logic [63:0]      advance;
	logic             ahead;
	logic             too_old;
	logic             dup;
	logic             replay_raw;
	logic [31:0]      bitmap_cur;
	logic [31:0]      bitmap_nxt;
	logic             spi_match;
	logic             commit_ok;

	// While holding, the arithmetic reruns on the matched entry so that a
	// commit sees the window as it stands then, not as it stood at lookup.
	assign sel_idx   = (rx_state_r == RX_HOLD) ? rx_idx_r : rx_scan_r;
	assign sel_flags = flags_mem[sel_idx];
	assign esn       = sel_flags[FLAG_ESN];
	assign top_hi    = top_hi_mem[sel_idx];
	assign top_lo    = top_lo_mem[sel_idx];
	assign bitmap_cur = bitmap_mem[sel_idx];
	assign lo_floor  = top_lo - WIN_FLOOR_OFS;
	assign spi_match = spi_cam_mem[rx_scan_r] == spi_r;

	always_comb begin
		seq_hi = 32'h0000_0000;
		if (esn) begin
			if (top_lo >= WIN_FLOOR_OFS) begin
				seq_hi = (seq_low_r >= lo_floor) ? top_hi : top_hi + 32'h0000_0001;
			end else begin
				seq_hi = (seq_low_r >= lo_floor) ? top_hi - 32'h0000_0001 : top_hi;
			end
		end
	end

	// The upper word of the top only counts when extended numbers are on.
	assign top64      = esn ? {top_hi, top_lo} : {32'h0000_0000, top_lo};
	assign seq64      = {seq_hi, seq_low_r};
	assign ahead      = seq64 > top64;
	assign behind     = top64 - seq64;
	assign advance    = seq64 - top64;
	assign too_old    = !ahead && (behind >= WIN_SPAN);
	assign dup        = !ahead && !too_old && bitmap_cur[behind[4:0]];
	assign replay_raw = too_old || dup;
	assign commit_ok  = (rx_state_r == RX_HOLD) && rx_commit_req && !rx_commit_drop
		&& !rx_miss_r && !replay_raw;

	always_comb begin
		if (ahead) begin
			bitmap_nxt = (advance >= WIN_SPAN) ? 32'h0000_0001
				: ((bitmap_cur << advance[4:0]) | 32'h0000_0001);
		end else begin
			bitmap_nxt = bitmap_cur | (32'h0000_0001 << behind[4:0]);
		end
	end

	// ---------------------------------------------------------------
	// Receive control
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rx_state_r     <= RX_IDLE;
			rx_scan_r      <= 8'h00;
			rx_idx_r       <= 8'h00;
			rx_miss_r      <= 1'b0;
			spi_r          <= 32'h0000_0000;
			seq_low_r      <= 32'h0000_0000;
			iv_r           <= 64'h0000_0000_0000_0000;
			rx_busy        <= 1'b0;
			rx_lookup_done <= 1'b0;
			rx_commit_done <= 1'b0;
		end else begin
			rx_lookup_done <= 1'b0;
			rx_commit_done <= 1'b0;
			case (rx_state_r)
				RX_IDLE: begin
					if (rx_lookup_req) begin
						spi_r      <= rx_spi;
						seq_low_r  <= rx_seq_low;
						iv_r       <= rx_iv;
						rx_scan_r  <= 8'h00;
						rx_busy    <= 1'b1;
						rx_state_r <= RX_SCAN;
					end
				end
				RX_SCAN: begin
					if (spi_match || rx_scan_r == LAST_ENTRY) begin
						rx_idx_r       <= rx_scan_r;
						rx_miss_r      <= !spi_match || !sel_flags[FLAG_ACTIVE];
						rx_lookup_done <= 1'b1;
						rx_state_r     <= RX_HOLD;
					end else begin
						rx_scan_r <= rx_scan_r + 8'h01;
					end
				end
				RX_HOLD: begin
					if (rx_commit_req) begin
						rx_commit_done <= 1'b1;
						rx_busy        <= 1'b0;
						rx_state_r     <= RX_IDLE;
					end
				end
				default: begin
					rx_state_r <= RX_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Receive answer
	// ---------------------------------------------------------------
	logic found_miss;
	logic replay_gate;

	assign found_miss  = !spi_match || !sel_flags[FLAG_ACTIVE];
	assign replay_gate = replay_raw && sel_flags[FLAG_REPLAY] && !found_miss;

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rx_miss     <= 1'b0;
			rx_replay   <= 1'b0;
			rx_drop     <= 1'b0;
			rx_index    <= 8'h00;
			rx_key_len  <= 2'h0;
			rx_key      <= '0;
			rx_nonce    <= '0;
			rx_seq_high <= 32'h0000_0000;
		end else if (rx_state_r == RX_SCAN && (spi_match || rx_scan_r == LAST_ENTRY)) begin
			rx_miss     <= found_miss;
			rx_replay   <= replay_gate;
			rx_drop     <= found_miss || replay_gate;
			rx_index    <= rx_scan_r;
			rx_key_len  <= sel_flags[FLAG_KEYLEN_LSB +: 2];
			rx_nonce    <= {salt_mem[rx_scan_r], iv_r};
			rx_seq_high <= seq_hi;
			for (int w = 0; w < KEY_WORDS; w++) begin
				rx_key[KEY_W-1-32*w -: 32] <= key_mem[{rx_scan_r, 3'(w)}];
			end
		end
	end

	// ---------------------------------------------------------------
	// Receive tables: host writes and window updates
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (host_wr && hit_spi) begin
			spi_cam_mem[idx_spi] <= host_wdata;
		end
		if (host_wr && hit_flags) begin
			flags_mem[idx_spi] <= host_wdata[FLAGS_W-1:0];
		end
		if (host_wr && hit_key) begin
			key_mem[host_addr[10:0]] <= host_wdata;
		end
		if (host_wr && hit_data && word_data == DW_SALT) begin
			salt_mem[idx_data] <= host_wdata;
		end
	end

	// The packet update wins over a host write to the same entry, so an
	// accepted packet is never lost to a concurrent table refresh.
	always_ff @(posedge clk) begin
		if (commit_ok) begin
			bitmap_mem[rx_idx_r] <= bitmap_nxt;
			if (ahead) begin
				top_lo_mem[rx_idx_r] <= seq64[31:0];
				if (esn) begin
					top_hi_mem[rx_idx_r] <= seq64[63:32];
				end
			end
		end
		if (host_wr && hit_data) begin
			case (word_data)
				DW_TOP_HIGH: begin
					if (!(commit_ok && ahead && esn && rx_idx_r == idx_data)) begin
						top_hi_mem[idx_data] <= host_wdata;
					end
				end
				DW_TOP_LOW: begin
					if (!(commit_ok && ahead && rx_idx_r == idx_data)) begin
						top_lo_mem[idx_data] <= host_wdata;
					end
				end
				DW_BITMAP: begin
					if (!(commit_ok && rx_idx_r == idx_data)) begin
						bitmap_mem[idx_data] <= host_wdata;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Policy table
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (host_wr && hit_pol) begin
			case (word_pol)
				PW_DST:      pol_dst[idx_key]    <= host_wdata;
				PW_DST_MASK: pol_dmask[idx_key]  <= host_wdata;
				PW_SRC:      pol_src[idx_key]    <= host_wdata;
				PW_SRC_MASK: pol_smask[idx_key]  <= host_wdata;
				PW_ACTIVE:   pol_active[idx_key] <= host_wdata[0];
				PW_INDEX:    pol_index[idx_key]  <= host_wdata[IDX_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Transmit policy scan
	// ---------------------------------------------------------------
	tx_state_t        tx_state_r;
	logic [IDX_W-1:0] tx_scan_r;
	logic [31:0]      tx_src_r;
	logic [31:0]      tx_dst_r;
	logic             pol_match;

	// One entry per cycle keeps the compare to a single 64-bit slice; the
	// first hit in index order is taken when several overlap.
	assign pol_match = pol_active[tx_scan_r]
		&& (((tx_dst_r ^ pol_dst[tx_scan_r]) & ~pol_dmask[tx_scan_r]) == 32'h0000_0000)
		&& (((tx_src_r ^ pol_src[tx_scan_r]) & ~pol_smask[tx_scan_r]) == 32'h0000_0000);

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tx_state_r       <= TX_IDLE;
			tx_scan_r        <= 8'h00;
			tx_src_r         <= 32'h0000_0000;
			tx_dst_r         <= 32'h0000_0000;
			tx_busy          <= 1'b0;
			tx_lookup_done   <= 1'b0;
			tx_hit           <= 1'b0;
			tx_index         <= 8'h00;
			tx_sa_read_en    <= 1'b0;
			tx_sa_read_index <= 8'h00;
		end else begin
			tx_lookup_done <= 1'b0;
			tx_sa_read_en  <= 1'b0;
			case (tx_state_r)
				TX_IDLE: begin
					if (tx_lookup_req) begin
						tx_src_r   <= tx_src;
						tx_dst_r   <= tx_dst;
						tx_scan_r  <= 8'h00;
						tx_busy    <= 1'b1;
						tx_state_r <= TX_SCAN;
					end
				end
				TX_SCAN: begin
					if (pol_match || tx_scan_r == LAST_ENTRY) begin
						tx_lookup_done   <= 1'b1;
						tx_hit           <= pol_match;
						tx_index         <= pol_index[tx_scan_r];
						tx_sa_read_en    <= pol_match;
						tx_sa_read_index <= pol_index[tx_scan_r];
						tx_busy          <= 1'b0;
						tx_state_r       <= TX_IDLE;
					end else begin
						tx_scan_r <= tx_scan_r + 8'h01;
					end
				end
				default: begin
					tx_state_r <= TX_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Host read path
	// ---------------------------------------------------------------
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (host_addr == ID_ADDR) begin
			rd_mux = ID_VALUE;
		end else if (hit_spi) begin
			rd_mux = spi_cam_mem[idx_spi];
		end else if (hit_flags) begin
			rd_mux = {27'h0000000, flags_mem[idx_spi]};
		end else if (hit_data) begin
			case (word_data)
				DW_TOP_HIGH: rd_mux = top_hi_mem[idx_data];
				DW_TOP_LOW:  rd_mux = top_lo_mem[idx_data];
				DW_SALT:     rd_mux = salt_mem[idx_data];
				default:     rd_mux = bitmap_mem[idx_data];
			endcase
		end else if (hit_key) begin
			rd_mux = key_mem[host_addr[10:0]];
		end else if (hit_pol) begin
			case (word_pol)
				PW_DST:      rd_mux = pol_dst[idx_key];
				PW_DST_MASK: rd_mux = pol_dmask[idx_key];
				PW_SRC:      rd_mux = pol_src[idx_key];
				PW_SRC_MASK: rd_mux = pol_smask[idx_key];
				PW_ACTIVE:   rd_mux = {31'h00000000, pol_active[idx_key]};
				PW_INDEX:    rd_mux = {24'h000000, pol_index[idx_key]};
				default:     rd_mux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			host_rdata  <= 32'h0000_0000;
			host_rvalid <= 1'b0;
		end else begin
			host_rvalid <= host_sel && !host_write;
			if (host_sel && !host_write) begin
				host_rdata <= rd_mux;
			end
		end
	end

endmodule

// >>> sa_datapath_model.sv
// Datapath stand-in that closes every receive lookup with one commit.
// Assumes the bench sets drop_next and slow before the lookup is answered.
`timescale 1ns/1ps

module sa_datapath_model (
	// Clock and bench controls
	input  wire logic clk, drop_next, slow,
	// Lookup handshake
	input  wire logic rx_lookup_done,
	output logic      rx_commit_req = 1'b0,
	output logic      rx_commit_drop = 1'b0
);
	logic late_r = 1'b0;

	// A slow commit waits one more cycle, as a busy integrity stage would.
	always @(posedge clk) begin
		late_r <= rx_lookup_done & slow;
		rx_commit_req <= (rx_lookup_done & ~slow) | late_r;
		rx_commit_drop <= ((rx_lookup_done & ~slow) | late_r) & drop_next;
	end
endmodule

// >>> sa_lookup_pkg.sv
// Constants shared by the association lookup and replay window block.
// Assumes a word-addressed host bus with 32-bit data and one 25 MHz clock.
package sa_lookup_pkg;

	// ---------------------------------------------------------------
	// Widths and table depths
	// ---------------------------------------------------------------
	localparam int          ADDR_W     = 14;
	localparam int          DATA_W     = 32;
	localparam int          IDX_W      = 8;
	localparam int          ENTRIES    = 256;
	localparam int          KEY_WORDS  = 8;
	localparam int          KEY_W      = 256;
	localparam int          IV_W       = 64;
	localparam int          NONCE_W    = 96;
	localparam int          FLAGS_W    = 5;
	localparam logic [7:0]  LAST_ENTRY = 8'hFF;

	// ---------------------------------------------------------------
	// Address map, compared against the upper address bits
	// ---------------------------------------------------------------
	localparam logic [5:0]  SPI_CAM_REGION = 6'h00;
	localparam logic [5:0]  FLAGS_REGION   = 6'h04;
	localparam logic [3:0]  DATA_REGION    = 4'h2;
	localparam logic [2:0]  KEY_REGION     = 3'h2;
	localparam logic [2:0]  POLICY_REGION  = 3'h6;
	localparam logic [13:0] ID_ADDR        = 14'h3802;

	// Value is arbitrary; only used to prove the host path works.
	localparam logic [31:0] ID_VALUE       = 32'h5A1E_0C01;

	// ---------------------------------------------------------------
	// Association flag word fields
	// ---------------------------------------------------------------
	localparam int          FLAG_KEYLEN_LSB = 0;
	localparam int          FLAG_ESN        = 2;
	localparam int          FLAG_REPLAY     = 3;
	localparam int          FLAG_ACTIVE     = 4;

	// ---------------------------------------------------------------
	// Word codes inside one data entry and one policy entry
	// ---------------------------------------------------------------
	localparam logic [1:0]  DW_TOP_HIGH = 2'h0;
	localparam logic [1:0]  DW_TOP_LOW  = 2'h1;
	localparam logic [1:0]  DW_SALT     = 2'h2;
	localparam logic [1:0]  DW_BITMAP   = 2'h3;

	localparam logic [2:0]  PW_DST      = 3'h0;
	localparam logic [2:0]  PW_DST_MASK = 3'h1;
	localparam logic [2:0]  PW_SRC      = 3'h2;
	localparam logic [2:0]  PW_SRC_MASK = 3'h3;
	localparam logic [2:0]  PW_ACTIVE   = 3'h4;
	localparam logic [2:0]  PW_INDEX    = 3'h5;

	// ---------------------------------------------------------------
	// Replay window
	// ---------------------------------------------------------------
	localparam logic [63:0] WIN_SPAN      = 64'h0000_0000_0000_0020;
	localparam logic [31:0] WIN_FLOOR_OFS = 32'h0000_001F;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_SCAN = 2'b01,
		RX_HOLD = 2'b10
	} rx_state_t;

	typedef enum logic [0:0] {
		TX_IDLE = 1'b0,
		TX_SCAN = 1'b1
	} tx_state_t;

endpackage

// >>> sa_lookup_properties.sv
// Port assertions for the association lookup block, attached by bind.
// Assumes one-cycle host read answers and sequential lookup scans.
`timescale 1ns/1ps

module sa_lookup_properties (
	// Clock, reset, host bus and lookup handshakes
	input wire logic       clk, reset_n, host_sel, host_write, host_rvalid,
	input wire logic       rx_lookup_req, rx_busy, rx_lookup_done, rx_miss, rx_replay, rx_drop,
	input wire logic       rx_commit_req, rx_commit_done, tx_lookup_done, tx_hit, tx_sa_read_en,
	input wire logic [7:0] tx_index, tx_sa_read_index
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_read_answer: assert property (host_sel && !host_write |=> host_rvalid)
		else $error("read strobe not answered");
	a_rvalid_cause: assert property (host_rvalid |-> $past(host_sel && !host_write))
		else $error("read answer without a read");
	a_drop_joins: assert property (rx_lookup_done |-> rx_drop == (rx_miss || rx_replay))
		else $error("drop differs from miss or replay");
	a_miss_quiet: assert property (rx_lookup_done && rx_miss |-> !rx_replay)
		else $error("missed packet flagged as replay");
	a_rx_bound: assert property (rx_lookup_req && !rx_busy |-> ##[2:257] rx_lookup_done)
		else $error("receive lookup not answered");
	a_commit_answer: assert property (rx_lookup_done ##1 rx_commit_req |=> rx_commit_done && !rx_busy)
		else $error("commit not answered");
	a_tx_read_hit: assert property (tx_lookup_done && tx_hit |-> tx_sa_read_en && tx_sa_read_index == tx_index)
		else $error("policy hit did not read association");
	a_tx_read_cause: assert property (tx_sa_read_en |-> tx_lookup_done && tx_hit)
		else $error("association read without policy hit");
endmodule

bind ipsec_sa_lookup_antireplay sa_lookup_properties u_props (.clk, .reset_n, .host_sel,
	.host_write, .host_rvalid, .rx_lookup_req, .rx_busy, .rx_lookup_done, .rx_miss, .rx_replay,
	.rx_drop, .rx_commit_req, .rx_commit_done, .tx_lookup_done, .tx_hit, .tx_sa_read_en,
	.tx_index, .tx_sa_read_index);

// >>> tb_top.sv
// Self-checking bench for the association lookup and replay window block.
// Assumes the datapath model answers every receive lookup with a commit.
`timescale 1ns/1ps

module tb_top;
	import sa_lookup_pkg::*;

	logic         clk = 1'b0, reset_n = 1'b0, host_sel = 1'b0, host_write = 1'b0;
	logic         rx_lookup_req = 1'b0, tx_lookup_req = 1'b0, drop_next = 1'b0, slow = 1'b0;
	logic [13:0]  host_addr = 14'h0000;
	logic [31:0]  host_wdata = 32'h0, rx_spi = 32'h0, rx_seq_low = 32'h0, tx_src = 32'h0;
	logic [31:0]  tx_dst = 32'h0, st = 32'hD608, s5, s7, k5, k7, host_rdata, rx_seq_high;
	logic [63:0]  rx_iv = 64'h0;
	logic [7:0]   rx_index, tx_index, tx_sa_read_index;
	logic [1:0]   rx_key_len;
	logic [255:0] rx_key;
	logic [95:0]  rx_nonce;
	logic         host_rvalid, rx_lookup_done, rx_miss, rx_replay, rx_drop, rx_busy, tx_busy;
	logic         rx_commit_req, rx_commit_drop, rx_commit_done, tx_lookup_done, tx_hit, tx_sa_read_en;
	logic [172:0] hq[$], rq[$], tq[$], rs;
	int           fails = 0, n_tests = 0, cyc = 0;

	ipsec_sa_lookup_antireplay DUT (.clk, .reset_n, .host_sel, .host_write, .host_addr,
		.host_wdata, .host_rdata, .host_rvalid, .rx_lookup_req, .rx_spi, .rx_seq_low, .rx_iv,
		.rx_lookup_done, .rx_miss, .rx_replay, .rx_drop, .rx_index, .rx_key_len, .rx_key,
		.rx_nonce, .rx_seq_high, .rx_busy, .rx_commit_req, .rx_commit_drop, .rx_commit_done,
		.tx_lookup_req, .tx_src, .tx_dst, .tx_lookup_done, .tx_hit, .tx_index, .tx_busy,
		.tx_sa_read_en, .tx_sa_read_index);
	sa_datapath_model partner (.clk, .drop_next, .slow, .rx_lookup_done, .rx_commit_req,
		.rx_commit_drop);

	initial forever #20 clk = ~clk;

	function automatic logic [31:0] xs();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction

	task automatic chk(input string nm, input logic [172:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// A read passes its expected word in d; the strobe stays up between calls.
	task automatic hw(input logic [13:0] a, input logic [31:0] d, input logic w);
		@(posedge clk);
		#1;
		{host_sel, host_write, host_addr, host_wdata} = {1'b1, w, a, d};
		if (!w) hq.push_back(173'(d));
	endtask

	task automatic hidle();
		@(posedge clk);
		#1;
		host_sel = 1'b0;
	endtask

	task automatic rx(input logic [31:0] spi, seq, input logic dr, m, r, input logic [7:0] ix,
		input logic [31:0] sh, sl, kh);
		@(posedge clk);
		#1;
		{rx_lookup_req, rx_spi, rx_seq_low, rx_iv, drop_next} = {1'b1, spi, seq, xs(), xs(), dr};
		rq.push_back({m | r, (ix == 8'h05) ? 2'b10 : 2'b00, m, r, ix,
			m ? 160'h0 : {sh, sl, rx_iv, kh}});
		@(posedge clk);
		#1;
		rx_lookup_req = 1'b0;
		for (int n = 0; n < 400 && rx_commit_done !== 1'b1; n++) @(negedge clk);
	endtask

	task automatic r5(input logic [31:0] seq, input logic dr, r);
		rx(32'hA000_0005, seq, dr, 1'b0, r, 8'h05, 32'h0, s5, k5);
	endtask

	task automatic tx(input logic [31:0] s, d, input logic h, input logic [7:0] ix);
		@(posedge clk);
		#1;
		{tx_lookup_req, tx_src, tx_dst} = {1'b1, s, d};
		tq.push_back(173'({h, ix}));
		@(posedge clk);
		#1;
		tx_lookup_req = 1'b0;
		for (int n = 0; n < 400 && tx_lookup_done !== 1'b1; n++) @(negedge clk);
	endtask

	always @(negedge clk) begin
		if (host_rvalid === 1'b1) chk("host_rdata", 173'(host_rdata), hq.pop_front());
		rs = {rx_drop, rx_key_len, rx_miss, rx_replay, rx_index, rx_seq_high, rx_nonce,
			rx_key[255:224]};
		if (rx_miss === 1'b1) rs[159:0] = 160'h0;
		if (rx_lookup_done === 1'b1) chk("rx result", rs, rq.pop_front());
		if (tx_lookup_done === 1'b1) chk("tx result", 173'({tx_hit, tx_hit ? tx_index : 8'h00}), tq.pop_front());
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			fails++;
			give_verdict();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		#1;
		reset_n = 1'b1;
		repeat (3) @(posedge clk);
		{s5, s7, k5, k7} = {xs(), xs(), xs(), xs()};
		for (int i = 0; i < 256; i++) begin
			hw(14'(i), 32'hA000_0000 + 32'(i), 1'b1);
			hw(14'(32'h400 + i), (i == 5) ? 32'h1A : (i == 7) ? 32'h14 : 32'h0, 1'b1);
			hw(14'(32'h3004 + i * 8), 32'h0, 1'b1);
		end
		for (int e = 1; e < 3; e++) begin
			hw(14'(32'h3008 + e * 8), 32'h0A00_0100, 1'b1);
			hw(14'(32'h3009 + e * 8), 32'h0000_00FF, 1'b1);
			hw(14'(32'h300A + e * 8), 32'hC0A8_0000, 1'b1);
			hw(14'(32'h300B + e * 8), 32'h0000_FFFF, 1'b1);
			hw(14'(32'h300D + e * 8), (e == 1) ? 32'h11 : 32'h5A, 1'b1);
		end
		hw(14'h301C, 32'h1, 1'b1);
		hw(14'h0814, 32'h0, 1'b1);
		hw(14'h0815, 32'h64, 1'b1);
		hw(14'h0816, s5, 1'b1);
		hw(14'h0817, 32'h1, 1'b1);
		hw(14'h081C, 32'h2, 1'b1);
		hw(14'h081D, 32'h10, 1'b1);
		hw(14'h081E, s7, 1'b1);
		hw(14'h081F, 32'h1, 1'b1);
		hw(14'h1028, k5, 1'b1);
		hw(14'h1038, k7, 1'b1);
		hw(14'h2000, 32'h1234, 1'b1);
		hw(14'h0405, 32'h1A, 1'b0);
		hw(14'h1028, k5, 1'b0);
		hw(14'h081E, s7, 1'b0);
		hw(14'h301D, 32'h5A, 1'b0);
		hw(14'h2000, 32'h0, 1'b0);
		hw(ID_ADDR, ID_VALUE, 1'b0);
		hidle();
		$display("test host tables done");
		r5(32'h64, 1'b0, 1'b1);
		r5(32'h45, 1'b0, 1'b0);
		r5(32'h44, 1'b0, 1'b1);
		r5(32'h45, 1'b0, 1'b1);
		r5(32'h65, 1'b1, 1'b0);
		r5(32'h65, 1'b0, 1'b0);
		r5(32'h65, 1'b0, 1'b1);
		slow = 1'b1;
		rx(32'hA000_0007, 32'hFFFF_FFF8, 1'b0, 1'b0, 1'b0, 8'h07, 32'h1, s7, k7);
		slow = 1'b0;
		rx(32'hA000_0007, 32'h11, 1'b0, 1'b0, 1'b0, 8'h07, 32'h2, s7, k7);
		rx(32'hA000_0007, 32'h11, 1'b0, 1'b0, 1'b0, 8'h07, 32'h2, s7, k7);
		rx(32'hA000_0003, 32'h1, 1'b0, 1'b1, 1'b0, 8'h03, 32'h0, 32'h0, 32'h0);
		rx(32'hDEAD_BEEF, 32'h1, 1'b0, 1'b1, 1'b0, 8'hFF, 32'h0, 32'h0, 32'h0);
		hw(14'h0815, 32'h65, 1'b0);
		hw(14'h0817, 32'h3, 1'b0);
		hw(14'h081C, 32'h2, 1'b0);
		hw(14'h081D, 32'h11, 1'b0);
		hw(14'h081F, 32'h0200_0003, 1'b0);
		hidle();
		$display("test replay window done");
		tx(32'hC0A8_1234, 32'h0A00_01FE, 1'b1, 8'h5A);
		tx(32'hC0A8_1234, 32'h0A00_0200, 1'b0, 8'h00);
		tx(32'hC0A9_0000, 32'h0A00_0100, 1'b0, 8'h00);
		repeat (2) @(posedge clk);
		$display("test policy match done");
		give_verdict();
	end
endmodule
